// ==== rtl/tpe_pkg.sv ====
// package: widths, reset values and carrier types for the type-c phy attach enable block
package tpe_pkg;

  localparam int unsigned TPE_NUM_ATTACH_PORTS = 3;
  localparam int unsigned TPE_NUM_MUX_PORTS    = 2;
  localparam int unsigned TPE_SYNC_STAGES      = 3;

  localparam logic TPE_POL_RESET  = 1'b0;
  localparam logic TPE_MODE_RESET = 1'b0;
  localparam logic TPE_PHY_RESET  = 1'b0;

  typedef enum logic [0:0] {
    TPE_MODE1 = 1'b0,
    TPE_MODE2 = 1'b1
  } tpe_mode_e;

  // raw pin group as sampled from the board
  typedef struct packed {
    logic [TPE_NUM_ATTACH_PORTS-1:0] attach;
    logic [TPE_NUM_MUX_PORTS-1:0]    orient;
    logic [TPE_NUM_MUX_PORTS-1:0]    mux_a;
    logic [TPE_NUM_MUX_PORTS-1:0]    mux_b;
    logic                            pol;
    logic                            mode;
  } tpe_pins_s;

  localparam int unsigned TPE_PINS_W = $bits(tpe_pins_s);

  // phy power enables per port
  typedef struct packed {
    logic [TPE_NUM_ATTACH_PORTS-1:0] phy_a;
    logic [TPE_NUM_ATTACH_PORTS-1:0] phy_b;
  } tpe_phy_s;

  typedef struct packed {
    tpe_pins_s s1;
    tpe_pins_s s2;
    tpe_pins_s s3;
    tpe_pins_s stable;
    tpe_phy_s  phy;
    tpe_mode_e mode;
  } tpe_state_s;

endpackage

// ==== rtl/tpe_attach_enable.sv ====
// top: powers the superspeed phys of each type-c port from attach and orientation pins in mode 1, or those of ports 0 and 1 from the mux pins in mode 2
`timescale 1ns/1ps

module tpe_attach_enable
  import tpe_pkg::*;
(
  input  wire logic                            sys_clk,
  input  wire logic                            rst_n,
  input  wire logic [TPE_NUM_ATTACH_PORTS-1:0] attach_detect_in,
  input  wire logic [TPE_NUM_MUX_PORTS-1:0]    port_orientation_in,
  input  wire logic [TPE_NUM_MUX_PORTS-1:0]    orient_a_attach_in,
  input  wire logic [TPE_NUM_MUX_PORTS-1:0]    orient_b_attach_in,
  input  wire logic                            input_polarity_sel,
  input  wire logic                            control_mode_sel,
  output logic      [TPE_NUM_ATTACH_PORTS-1:0] phy_a_enable,
  output logic      [TPE_NUM_ATTACH_PORTS-1:0] phy_b_enable,
  output logic                                 mode2_active
);

  tpe_state_s state;
  tpe_state_s next_state;
  tpe_pins_s  raw;
  tpe_pins_s  norm;
  tpe_phy_s   phy_mode1;
  tpe_phy_s   phy_mode2;
  tpe_mode_e  mode_sel;

  // polarity select inverts every attach-type pin; pol and mode pass unchanged
  function automatic tpe_pins_s tpe_normalise(input tpe_pins_s p);
    tpe_pins_s r;
    r = p;
    if (p.pol) begin
      r.attach = ~p.attach;
      r.orient = ~p.orient;
      r.mux_a  = ~p.mux_a;
      r.mux_b  = ~p.mux_b;
    end
    return r;
  endfunction

  // per-bit filter: a bit takes the new level only where the middle and the
  // last stage agree, so a level caught mid-edge never reaches the decoders
  function automatic tpe_pins_s tpe_sync_agree(input tpe_pins_s mid,
                                               input tpe_pins_s late,
                                               input tpe_pins_s held);
    logic [TPE_PINS_W-1:0] agree;
    agree = ~(mid ^ late);
    return tpe_pins_s'((mid & agree) | (held & ~agree));
  endfunction

  // mode 1: attach powers the port, orientation steers between the phys
  function automatic tpe_phy_s tpe_decode_mode1(input tpe_pins_s p);
    tpe_phy_s r;
    r = '0;
    for (int i = 0; i < int'(TPE_NUM_MUX_PORTS); i++) begin
      if (p.attach[i]) begin
        if (p.orient[i]) begin
          r.phy_b[i] = 1'b1;
        end else begin
          r.phy_a[i] = 1'b1;
        end
      end
    end
    // ports without an orientation pin have no flip and power phy a
    for (int i = int'(TPE_NUM_MUX_PORTS); i < int'(TPE_NUM_ATTACH_PORTS); i++) begin
      r.phy_a[i] = p.attach[i];
    end
    return r;
  endfunction

  // mode 2: one attach pin per orientation; ports without mux pins stay off
  function automatic tpe_phy_s tpe_decode_mode2(input tpe_pins_s p);
    tpe_phy_s r;
    r = '0;
    for (int i = 0; i < int'(TPE_NUM_MUX_PORTS); i++) begin
      r.phy_a[i] = p.mux_a[i];
      r.phy_b[i] = p.mux_b[i];
    end
    return r;
  endfunction

  function automatic tpe_mode_e tpe_select_mode(input tpe_pins_s p);
    tpe_mode_e m;
    m = p.mode ? TPE_MODE2 : TPE_MODE1;
    return m;
  endfunction

  always_comb begin
    raw.attach = attach_detect_in;
    raw.orient = port_orientation_in;
    raw.mux_a  = orient_a_attach_in;
    raw.mux_b  = orient_b_attach_in;
    raw.pol    = input_polarity_sel;
    raw.mode   = control_mode_sel;
  end

  assign norm = tpe_normalise(state.stable);

  // both decoders run all the time; the mode only picks one result, which
  // keeps the mux small and leaves the inactive pin set without effect
  assign phy_mode1 = tpe_decode_mode1(norm);
  assign phy_mode2 = tpe_decode_mode2(norm);
  assign mode_sel  = tpe_select_mode(norm);

  always_comb begin
    next_state        = state;
    // three stages; only the first ever sees a pin that may be metastable
    next_state.s1     = raw;
    next_state.s2     = state.s1;
    next_state.s3     = state.s2;
    next_state.stable = tpe_sync_agree(state.s2, state.s3, state.stable);

    next_state.mode = mode_sel;

    case (mode_sel)
      TPE_MODE1: begin
        // mux pins are ignored in this mode
        next_state.phy = phy_mode1;
      end
      TPE_MODE2: begin
        // attach and orientation pins are ignored in this mode
        next_state.phy = phy_mode2;
      end
      default: begin
        next_state.phy = '0;
      end
    endcase
  end

  // reset values match the pulled-down pins: polarity low, mode 1, phys off
  localparam tpe_pins_s PINS_RESET = '{attach: '0, orient: '0, mux_a: '0, mux_b: '0,
                                      pol: TPE_POL_RESET, mode: TPE_MODE_RESET};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state.s1     <= PINS_RESET;
      state.s2     <= PINS_RESET;
      state.s3     <= PINS_RESET;
      state.stable <= PINS_RESET;
      state.phy    <= '{phy_a: {TPE_NUM_ATTACH_PORTS{TPE_PHY_RESET}},
                        phy_b: {TPE_NUM_ATTACH_PORTS{TPE_PHY_RESET}}};
      state.mode   <= TPE_MODE1;
    end else begin
      state <= next_state;
    end
  end

  assign phy_a_enable = state.phy.phy_a;
  assign phy_b_enable = state.phy.phy_b;
  assign mode2_active = (state.mode == TPE_MODE2);

endmodule

// ==== verif/tpe_cc_model.sv ====
// stand-in for the type-c controller that drives the attach pins
`timescale 1ns/1ps
module tpe_cc_model
  import tpe_pkg::*;
(
  input  wire logic      sys_clk,
  input  wire tpe_pins_s req,
  output tpe_pins_s      pins
);
  initial pins = '0;
  // req holds normalised levels; the pins show them at the chosen polarity
  always @(posedge sys_clk) begin
    pins <= #1 req ^ {{9{req.pol}}, 2'h0};
  end
endmodule

// ==== verif/tpe_attach_props.sv ====
// assertions on the phy enables of the attach enable block
`timescale 1ns/1ps
module tpe_attach_props
  import tpe_pkg::*;
(
  input logic       sys_clk,
  input logic       rst_n,
  input logic [2:0] attach_detect_in,
  input logic [1:0] port_orientation_in,
  input logic [1:0] orient_a_attach_in,
  input logic [1:0] orient_b_attach_in,
  input logic       input_polarity_sel,
  input logic       control_mode_sel,
  input logic [2:0] phy_a_enable,
  input logic [2:0] phy_b_enable,
  input logic       mode2_active
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire       p   = input_polarity_sel;
  wire [2:0] at  = attach_detect_in ^ {3{p}};
  wire [1:0] ori = port_orientation_in ^ {2{p}};
  wire [2:0] ea  = control_mode_sel ? {1'b0, orient_a_attach_in ^ {2{p}}} : at & {1'b1, ~ori};
  wire [2:0] eb  = control_mode_sel ? {1'b0, orient_b_attach_in ^ {2{p}}} : {1'b0, at[1:0] & ori};
  wire [10:0] pin = {attach_detect_in, port_orientation_in, orient_a_attach_in,
                     orient_b_attach_in, p, control_mode_sel};
  // outputs trail the pins through the synchroniser, so judge only settled pins
  sequence settled;
    $stable(pin)[*8];
  endsequence
  chk_phy_a_match: assert property (settled |-> phy_a_enable == ea) else $error("phy a");
  chk_phy_b_match: assert property (settled |-> phy_b_enable == eb) else $error("phy b");
  chk_mode_follow: assert property (settled |-> mode2_active == control_mode_sel) else $error("mode");
  chk_b2_off: assert property (phy_b_enable[2] == 1'b0) else $error("port 2 b");
  chk_mode1_excl: assert property (!mode2_active |-> !(phy_a_enable & phy_b_enable)) else $error("a and b");
  chk_mode2_late: assert property ($rose(mode2_active) |-> $past(control_mode_sel, 3)) else $error("early");
  chk_reset_off: assert property ($rose(rst_n) |-> !{phy_a_enable, phy_b_enable}) else $error("reset");
  chk_mode2_p2: assert property (mode2_active |-> !phy_a_enable[2]) else $error("port 2 a");
endmodule
bind tpe_attach_enable tpe_attach_props u_tpe_attach_props (.*);

// ==== verif/tpe_attach_enable_test.sv ====
// random bench comparing the phy enables with a reference model
`timescale 1ns/1ps
module tpe_attach_enable_test;
  import tpe_pkg::*;
  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  tpe_pins_s  req = '0;
  tpe_pins_s  pins;
  tpe_phy_s   got;
  logic       m2;
  logic [2:0] ea, eb;
  int         fail_count = 0;
  int         tests_run = 0;
  int         seed = 32'hdca9_5438;
  always #4 sys_clk = ~sys_clk;
  tpe_cc_model u_tpe_cc_model (.sys_clk(sys_clk), .req(req), .pins(pins));
  tpe_attach_enable u_tpe_attach_enable (.sys_clk(sys_clk), .rst_n(rst_n),
    .attach_detect_in(pins.attach), .port_orientation_in(pins.orient),
    .orient_a_attach_in(pins.mux_a), .orient_b_attach_in(pins.mux_b),
    .input_polarity_sel(pins.pol), .control_mode_sel(pins.mode),
    .phy_a_enable(got.phy_a), .phy_b_enable(got.phy_b), .mode2_active(m2));
  task automatic cmp(input logic [2:0] g, input logic [2:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_mode(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic end_sim();
    if (fail_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    for (int n = 0; n < 300; n++) begin
      req = tpe_pins_s'($random(seed));
      if (n == 150) begin
        rst_n = 1'b0;
        #9 cmp(got.phy_a | got.phy_b, 3'h0);
        rst_n = 1'b1;
      end
      repeat (9) @(posedge sys_clk);
      #1;
      for (int i = 0; i < 3; i++) begin
        ea[i] = req.mode ? i < 2 && req.mux_a[i] : req.attach[i] && (i == 2 || !req.orient[i]);
        eb[i] = i < 2 && (req.mode ? req.mux_b[i] : req.attach[i] && req.orient[i]);
      end
      cmp(got.phy_a, ea);
      cmp(got.phy_b, eb);
      cmp_mode(m2, req.mode);
    end
    end_sim();
  end
endmodule
